/* hw/swp_pkg.sv */
// constants and types shared by the writeback packer files
package swp_pkg;
  // apb register offsets (byte addresses)
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_STATUS    = 12'h004;
  localparam logic [11:0] ADDR_REPLY_CNT = 12'h008;
  // control register fields and reset value
  localparam int          CTRL_EN_BIT    = 0;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0001;
  // status register field positions
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_FMT16_BIT = 1;
  localparam int          STAT_MASK_BIT  = 2;
  localparam int          STAT_SLOT_LSB  = 4;
  localparam int          STAT_POS_LSB   = 8;
  // geometry of one reply
  localparam int          NUM_CH         = 4;
  localparam int          NUM_PIX        = 8;
  localparam int          REG_W          = 256;
  // slot codes: 0..3 colour channels, then the flag register
  localparam logic [2:0]  SLOT_FLAG      = 3'h4;
  localparam logic [2:0]  SLOT_NONE      = 3'h5;
  // flag register dword 0 layout
  localparam int          FLAG_HI_LSB    = 24;
  localparam int          FLAG_BORDER_LSB = 16;
  localparam int          FLAG_LO_LSB    = 8;
  localparam int          FLAG_NULL_LSB  = 0;
  localparam logic [7:0]  FLAG_FILL      = 8'hFF;
  localparam logic [15:0] FLAG_DISPATCH  = 16'hFFFF;
  // only dword 0 of the flag register is written (both halves)
  localparam logic [15:0] FLAG_HW_EN     = 16'h0003;
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SEND} swp_state_t;
endpackage

/* hw/swp_chan_fmt.sv */
// lays eight pixel values of one channel out into a destination register
`timescale 1ns/100ps
module swp_chan_fmt (
  input  wire logic         fmt16,     // 1: 16-bit return format
  input  wire logic [7:0]   exec_mask, // pixel lanes enabled by the send
  input  wire logic [255:0] pix,       // pixel i value in bits 32i+31:32i
  output logic      [255:0] data,      // formatted register contents
  output logic      [15:0]  hw_en      // write enable per 16-bit half
);
  genvar i;
  generate
    for (i = 0; i < swp_pkg::NUM_PIX; i++) begin : g_dw
      // split by dword so no branch indexes past the pixel vectors
      if (i < swp_pkg::NUM_PIX / 2) begin : g_lo
        always_comb begin
          if (!fmt16) begin
            data[i*32 +: 32] = pix[i*32 +: 32];  // R5 R6
            hw_en[i*2 +: 2]  = {2{exec_mask[i]}};  // R3
          end else begin
            // even pixel low half, odd pixel high half
            data[i*32 +: 32] = {pix[(2*i+1)*32 +: 16],
                                pix[2*i*32 +: 16]};  // R14 R15
            hw_en[i*2 +: 2]  = {exec_mask[2*i+1], exec_mask[2*i]};  // R3
          end
        end
      end else begin : g_hi
        always_comb begin
          if (!fmt16) begin
            data[i*32 +: 32] = pix[i*32 +: 32];  // R5 R6
            hw_en[i*2 +: 2]  = {2{exec_mask[i]}};  // R3
          end else begin
            data[i*32 +: 32] = 32'h0000_0000;  // R14
            hw_en[i*2 +: 2]  = 2'h0;
          end
        end
      end
    end
  endgenerate
endmodule // swp_chan_fmt

/* hw/swp_flag_word.sv */
// builds dword 0 of the extra flag register
`timescale 1ns/100ps
module swp_flag_word (
  input  wire logic        fmt16,       // 1: 16-bit return format
  input  wire logic        killpix,     // sample-with-kill-pixel request
  input  wire logic [7:0]  alive_mask,  // 0: pixel killed by chroma key
  input  wire logic [7:0]  border_mask, // 0: pixel used border colour
  input  wire logic [7:0]  null_mask,   // 0: pixel touched a null page
  output logic      [31:0] word         // flag dword 0
);
  always_comb begin
    if (!fmt16 && killpix) begin
      // upper half lets the thread AND it with its dispatch header
      word = {swp_pkg::FLAG_DISPATCH, swp_pkg::FLAG_FILL, alive_mask}; // R9 R10
    end else begin
      word = {swp_pkg::FLAG_FILL, border_mask,
              swp_pkg::FLAG_FILL, null_mask};  // R11 R12 R13 R17
    end
  end
endmodule // swp_flag_word

/* hw/swp_packer.sv */
// eight-lane sampler writeback packer with apb control and status
//
// Summary of operation
// R1: 32-bit reply: four registers, five with kill
// R2: skip disabled channels, pack the rest contiguously
// R3: write only lanes enabled by execution mask
// R4: kill reply appends flag register after channels
// R5: 32-bit: dword per pixel, two subspans ordered
// R6: 32-bit values: float, signed or unsigned
// R7: green blue alpha follow red layout
// R8: 32-bit flag only for kill or null-mask
// R9: kill flag dword upper half all ones
// R10: kill low half: alive bits, high eight ones
// R11: null-mask: bits 31:24, 15:8 all ones
// R12: bits 23:16 clear where border colour used
// R13: bits 7:0 clear where null page used
// R14: 16-bit: two pixels per dword, 7:4 reserved
// R15: 16-bit values: half, signed or unsigned
// R16: 16-bit flag only with fault mask enable
// R17: 16-bit flag: fill ones, border, null
// R18: thread reserves registers, counts enabled channels
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/100ps
module swp_packer (
  input  wire logic         pclk,            // clock, 100 MHz
  input  wire logic         presetn,         // async reset, active low
  input  wire logic [11:0]  paddr,           // apb byte address
  input  wire logic         psel,            // apb select
  input  wire logic         penable,         // apb access phase
  input  wire logic         pwrite,          // apb write
  input  wire logic [31:0]  pwdata,          // apb write data
  output logic      [31:0]  prdata,          // apb read data
  output logic              pready,          // apb ready
  output logic              pslverr,         // apb error, unmapped
  input  wire logic         req_valid,       // sampler result valid
  output logic              req_ready,       // packer takes result
  input  wire logic         req_fmt16,       // 16-bit return format
  input  wire logic         req_killpix,     // sample-with-kill-pixel
  input  wire logic         req_null_en,     // header null-mask enable
  input  wire logic         req_fault_en,    // pixel fault mask enable
  input  wire logic [3:0]   req_ch_off,      // 1: channel disabled
  input  wire logic [7:0]   req_exec_mask,   // send execution mask
  input  wire logic [7:0]   req_base_reg,    // first destination reg
  input  wire logic [255:0] req_red,         // red, pixel i at 32i
  input  wire logic [255:0] req_green,       // green, same layout
  input  wire logic [255:0] req_blue,        // blue, same layout
  input  wire logic [255:0] req_alpha,       // alpha, same layout
  input  wire logic [7:0]   req_alive_mask,  // 0: chroma-key killed
  input  wire logic [7:0]   req_border_mask, // 0: border colour used
  input  wire logic [7:0]   req_null_mask,   // 0: null page used
  output logic              wb_valid,        // register beat valid
  input  wire logic         wb_ready,        // thread takes beat
  output logic      [7:0]   wb_reg,          // destination register
  output logic      [255:0] wb_data,         // register contents
  output logic      [15:0]  wb_hw_en,        // 16-bit half enables
  output logic              wb_is_flag,      // beat is flag register
  output logic              wb_last          // last beat of reply
);

  swp_pkg::swp_state_t state_ff;
  swp_pkg::swp_state_t nxt_state;

  logic [255:0] ch_data_ff [swp_pkg::NUM_CH];
  logic         fmt16_ff;
  logic         killpix_ff;
  logic         null_en_ff;
  logic         flag_need_ff;
  logic [3:0]   ch_off_ff;
  logic [7:0]   exec_ff;
  logic [7:0]   base_ff;
  logic [7:0]   alive_ff;
  logic [7:0]   border_ff;
  logic [7:0]   null_ff;
  logic [2:0]   slot_ff;
  logic [2:0]   pos_ff;
  logic [7:0]   wb_reg_ff;
  logic [255:0] wb_data_ff;
  logic [15:0]  wb_hw_en_ff;
  logic         wb_flag_ff;
  logic         wb_last_ff;
  logic [31:0]  ctrl_ff;
  logic [15:0]  reply_cnt_ff;
  logic [31:0]  prdata_ff;
  logic         pslverr_ff;

  logic         take;
  logic         beat_done;
  logic         flag_need;
  logic [2:0]   first_slot;
  logic [2:0]   cur_slot;
  logic [2:0]   after_slot;
  logic [255:0] fmt_data;
  logic [15:0]  fmt_hw_en;
  logic [31:0]  flag_word;
  logic         apb_setup;
  logic         apb_write;
  logic [31:0]  status_word;

  // first slot at or after start that carries a register, else none;
  // disabled channels are simply passed over, so later ones drop down
  function automatic logic [2:0] slot_from(
    input logic [2:0] start,
    input logic [3:0] off,
    input logic       need_flag
  );
    logic [2:0] res;
    res = swp_pkg::SLOT_NONE;
    for (int c = swp_pkg::NUM_CH - 1; c >= 0; c--) begin
      if ((3'(c) >= start) && !off[c]) begin  // R2
        res = 3'(c);
      end
    end
    if ((res == swp_pkg::SLOT_NONE) && need_flag &&
        (start <= swp_pkg::SLOT_FLAG)) begin
      res = swp_pkg::SLOT_FLAG;  // R4
    end
    return res;
  endfunction

  // 32-bit: flag only for kill or null-mask; 16-bit: fault mask enable
  assign flag_need = req_fmt16 ? req_fault_en  // R16
                               : (req_killpix | req_null_en);  // R8

  assign first_slot = slot_from(3'h0, req_ch_off, flag_need);
  assign cur_slot   = slot_ff;
  assign after_slot = slot_from(3'(slot_ff + 3'h1), ch_off_ff,
                                flag_need_ff);

  // a request with nothing to send is still taken, and simply dropped
  assign req_ready = (state_ff == swp_pkg::ST_IDLE) &&
                     ctrl_ff[swp_pkg::CTRL_EN_BIT];
  assign take      = req_valid && req_ready;
  assign beat_done = (state_ff == swp_pkg::ST_SEND) && wb_ready;

  // ---------------------------------------------------------------
  // request capture
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt16_ff     <= 1'b0;
      killpix_ff   <= 1'b0;
      null_en_ff   <= 1'b0;
      flag_need_ff <= 1'b0;
      ch_off_ff    <= 4'h0;
      exec_ff      <= 8'h00;
      base_ff      <= 8'h00;
      alive_ff     <= 8'h00;
      border_ff    <= 8'h00;
      null_ff      <= 8'h00;
    end else if (take) begin
      fmt16_ff     <= req_fmt16;
      killpix_ff   <= req_killpix;
      null_en_ff   <= req_null_en;
      flag_need_ff <= flag_need;
      ch_off_ff    <= req_ch_off;
      exec_ff      <= req_exec_mask;
      base_ff      <= req_base_reg;
      alive_ff     <= req_alive_mask;
      border_ff    <= req_border_mask;
      null_ff      <= req_null_mask;
    end
  end

  // fixed slot order red, green, blue, alpha before compaction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < swp_pkg::NUM_CH; c++) begin
        ch_data_ff[c] <= '0;
      end
    end else if (take) begin
      ch_data_ff[0] <= req_red;
      ch_data_ff[1] <= req_green;  // R7
      ch_data_ff[2] <= req_blue;  // R7
      ch_data_ff[3] <= req_alpha;  // R7
    end
  end

  // ---------------------------------------------------------------
  // sequencing: one load cycle, then hold the beat until taken
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      swp_pkg::ST_IDLE: begin
        if (take && (first_slot != swp_pkg::SLOT_NONE)) begin
          nxt_state = swp_pkg::ST_LOAD;
        end
      end
      swp_pkg::ST_LOAD: nxt_state = swp_pkg::ST_SEND;
      swp_pkg::ST_SEND: begin
        if (wb_ready) begin
          nxt_state = wb_last_ff ? swp_pkg::ST_IDLE : swp_pkg::ST_LOAD;
        end
      end
      default: nxt_state = swp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= swp_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // slot being sent and its position counted from the base register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_ff <= swp_pkg::SLOT_NONE;
      pos_ff  <= 3'h0;
    end else if (take) begin
      slot_ff <= first_slot;
      pos_ff  <= 3'h0;
    end else if (beat_done && !wb_last_ff) begin
      slot_ff <= after_slot;  // R2
      pos_ff  <= 3'(pos_ff + 3'h1);  // R2
    end
  end

  swp_chan_fmt u_chan_fmt (
    .fmt16     (fmt16_ff),
    .exec_mask (exec_ff),
    .pix       (ch_data_ff[cur_slot[1:0]]),
    .data      (fmt_data),
    .hw_en     (fmt_hw_en)
  );

  swp_flag_word u_flag_word (
    .fmt16       (fmt16_ff),
    .killpix     (killpix_ff),
    .alive_mask  (alive_ff),
    .border_mask (border_ff),
    .null_mask   (null_ff),
    .word        (flag_word)
  );

  // beat registers, loaded in the load cycle so outputs are flopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_reg_ff   <= 8'h00;
      wb_data_ff  <= '0;
      wb_hw_en_ff <= 16'h0000;
      wb_flag_ff  <= 1'b0;
      wb_last_ff  <= 1'b0;
    end else if (state_ff == swp_pkg::ST_LOAD) begin
      wb_reg_ff  <= 8'(base_ff + {5'h00, pos_ff});  // R2
      wb_last_ff <= (after_slot == swp_pkg::SLOT_NONE);  // R1
      if (cur_slot == swp_pkg::SLOT_FLAG) begin
        // dwords 1..7 of the flag register are never written
        wb_data_ff  <= {224'h0, flag_word};  // R8 R16
        wb_hw_en_ff <= swp_pkg::FLAG_HW_EN;  // R8 R16
        wb_flag_ff  <= 1'b1;  // R4
      end else begin
        wb_data_ff  <= fmt_data;  // R5 R14
        wb_hw_en_ff <= fmt_hw_en;  // R3
        wb_flag_ff  <= 1'b0;
      end
    end
  end

  assign wb_valid   = (state_ff == swp_pkg::ST_SEND);
  assign wb_reg     = wb_reg_ff;
  assign wb_data    = wb_data_ff;
  assign wb_hw_en   = wb_hw_en_ff;
  assign wb_is_flag = wb_flag_ff;
  assign wb_last    = wb_last_ff;

  // ---------------------------------------------------------------
  // apb slave: zero wait states, read data captured in setup
  // ---------------------------------------------------------------
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;

  assign status_word = {16'h0000, 5'h00, pos_ff,
                        1'b0, slot_ff, 1'b0, flag_need_ff, fmt16_ff,
                        (state_ff != swp_pkg::ST_IDLE)};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= swp_pkg::CTRL_RST;
    end else if (apb_write && (paddr == swp_pkg::ADDR_CTRL)) begin
      // clearing enable stalls new requests; a reply in flight finishes
      ctrl_ff <= {31'h0, pwdata[swp_pkg::CTRL_EN_BIT]};
    end
  end

  // counts whole replies handed to the thread; wraps silently
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reply_cnt_ff <= 16'h0000;
    end else if (beat_done && wb_last_ff) begin
      reply_cnt_ff <= 16'(reply_cnt_ff + 16'h0001);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (apb_setup) begin
      pslverr_ff <= 1'b0;
      case (paddr)
        swp_pkg::ADDR_CTRL:      prdata_ff <= ctrl_ff;
        swp_pkg::ADDR_STATUS:    prdata_ff <= status_word;
        swp_pkg::ADDR_REPLY_CNT: prdata_ff <= {16'h0000, reply_cnt_ff};
        default: begin
          prdata_ff  <= 32'h0000_0000;
          pslverr_ff <= 1'b1;
        end
      endcase
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = 1'b1;
  assign pslverr = pslverr_ff & psel & penable;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_MAX_REGS: assert property (  // R1
    @(posedge pclk) disable iff (!presetn)
    wb_valid |-> (pos_ff <= (wb_is_flag ? 3'h4 : 3'h3)))
    else $error("reply exceeds its register budget");

  AST_COMPACT: assert property (  // R2
    @(posedge pclk) disable iff (!presetn)
    (wb_valid && wb_ready && !wb_last) |->
      ##2 (wb_valid && (wb_reg == 8'($past(wb_reg, 2) + 8'h01))))
    else $error("next register is not the following one");

  AST_SKIP_OFF: assert property (  // R2
    @(posedge pclk) disable iff (!presetn)
    (wb_valid && !wb_is_flag) |-> !ch_off_ff[slot_ff[1:0]])
    else $error("disabled channel was sent");

  AST_LANES32: assert property (  // R3
    @(posedge pclk) disable iff (!presetn)
    (wb_valid && !wb_is_flag && !fmt16_ff) |->
      (wb_hw_en == {exec_ff[7], exec_ff[7], exec_ff[6], exec_ff[6],
                    exec_ff[5], exec_ff[5], exec_ff[4], exec_ff[4],
                    exec_ff[3], exec_ff[3], exec_ff[2], exec_ff[2],
                    exec_ff[1], exec_ff[1], exec_ff[0], exec_ff[0]}))
    else $error("lane enables differ from execution mask");

  AST_FLAG_LAST: assert property (  // R4
    @(posedge pclk) disable iff (!presetn)
    (wb_valid && wb_is_flag) |-> (wb_last && wb_hw_en == 16'h0003))
    else $error("flag register not last or writes extra dwords");

  AST_KILL_FLAG: assert property (  // R4
    @(posedge pclk) disable iff (!presetn)
    (wb_valid && wb_last && killpix_ff && !fmt16_ff) |-> wb_is_flag)
    else $error("kill reply ended without flag register");

  AST_KILL_HI: assert property (  // R9
    @(posedge pclk) disable iff (!presetn)
    (wb_valid && wb_is_flag && killpix_ff && !fmt16_ff) |->
      (wb_data[31:8] == 24'hFFFFFF && wb_data[7:0] == alive_ff))
    else $error("kill flag dword malformed");

  AST_NULL_FILL: assert property (  // R11
    @(posedge pclk) disable iff (!presetn)
    (wb_valid && wb_is_flag && (fmt16_ff || !killpix_ff)) |->
      (wb_data[31:24] == 8'hFF && wb_data[15:8] == 8'hFF &&
       wb_data[23:16] == border_ff && wb_data[7:0] == null_ff))
    else $error("null-mask flag dword malformed");

  AST_RES16: assert property (  // R14
    @(posedge pclk) disable iff (!presetn)
    (wb_valid && fmt16_ff && !wb_is_flag) |->
      (wb_hw_en[15:8] == 8'h00))
    else $error("reserved 16-bit dwords written");

  AST_NO_FLAG16: assert property (  // R16
    @(posedge pclk) disable iff (!presetn)
    (wb_valid && wb_is_flag && fmt16_ff) |->
      (flag_need_ff && wb_last))
    else $error("16-bit flag sent without fault mask enable");

endmodule // swp_packer

/* bench/swp_thread_model.sv */
// shader thread stand-in that accepts writeback beats at a chosen pace
`timescale 1ns/100ps
module swp_thread_model (
  input  wire logic        pclk,     // clock
  input  wire logic        presetn,  // async reset, active low
  input  wire logic        wb_valid, // beat offered
  input  wire logic [1:0]  pace,     // 0 prompt, 1 random, 2 slow
  output logic             wb_ready, // beat accepted
  output logic      [15:0] beats     // beats taken so far
);
  logic [15:0] lfsr_ff;
  logic [1:0]  cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_ff <= 16'h0048;
      cnt_ff <= 2'h0;
    end else begin
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[10]};
      cnt_ff <= cnt_ff + 2'h1;
    end
  end
  // a real thread may stall at any time, so ready is not tied to valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_ready <= 1'b0;
    end else begin
      case (pace)
        2'h0: wb_ready <= 1'b1;
        2'h1: wb_ready <= lfsr_ff[0];
        default: wb_ready <= (cnt_ff == 2'h3);
      endcase
    end
  end
  // registers are reserved by counting beats from the base onward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beats <= 16'h0000;
    end else if (wb_valid && wb_ready) begin
      beats <= beats + 16'h0001;
    end
  end
endmodule // swp_thread_model

/* bench/test_swp_packer.sv */
// self-checking bench for the writeback packer
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin \
  miscompares++; $display("[FAIL] %0t %s", $time, msg); end end
module test_swp_packer;
  typedef struct packed {
    logic [7:0]   rg;
    logic [255:0] data;
    logic [15:0]  hw_en;
    logic         flag;
    logic         last;
  } swp_beat_t;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic         req_valid, req_ready, req_fmt16, req_killpix, err;
  logic         req_null_en, req_fault_en, wb_valid, wb_ready;
  logic         wb_is_flag, wb_last;
  logic [3:0]   req_ch_off;
  logic [7:0]   req_exec_mask, req_base_reg, wb_reg;
  logic [7:0]   req_alive_mask, req_border_mask, req_null_mask;
  logic [255:0] req_red, req_green, req_blue, req_alpha, wb_data;
  logic [15:0]  wb_hw_en, beats;
  logic [15:0]  seed = 16'h0048;
  logic [1:0]   pace;
  swp_beat_t    q[$];
  swp_beat_t    e;
  int           checks, miscompares, exp_beats;

  swp_packer dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req_ready(req_ready), .req_fmt16(req_fmt16),
    .req_killpix(req_killpix), .req_null_en(req_null_en),
    .req_fault_en(req_fault_en), .req_ch_off(req_ch_off),
    .req_exec_mask(req_exec_mask), .req_base_reg(req_base_reg),
    .req_red(req_red), .req_green(req_green), .req_blue(req_blue),
    .req_alpha(req_alpha), .req_alive_mask(req_alive_mask),
    .req_border_mask(req_border_mask), .req_null_mask(req_null_mask),
    .wb_valid(wb_valid), .wb_ready(wb_ready), .wb_reg(wb_reg),
    .wb_data(wb_data), .wb_hw_en(wb_hw_en), .wb_is_flag(wb_is_flag),
    .wb_last(wb_last));
  swp_thread_model thread (.pclk(pclk), .presetn(presetn),
    .wb_valid(wb_valid), .pace(pace), .wb_ready(wb_ready), .beats(beats));

  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // m: bit0 16-bit, bit1 kill, bit2 null enable, bit3 fault enable
  task automatic send_req(input logic [3:0] m, input logic [3:0] off);
    logic [255:0] ch [4];
    logic [7:0]   ex, bs, al, bo, nu, pad;
    logic [31:0]  fw;
    logic         need;
    int           tot, n;
    swp_beat_t    b;
    for (int c = 0; c < 4; c++)
      for (int k = 0; k < 16; k++) ch[c][16*k+:16] = rnd();
    {ex, bs} = rnd();
    {al, bo} = rnd();
    {nu, pad} = rnd();
    @(posedge pclk);
    req_valid <= 1'b1;
    {req_fault_en, req_null_en, req_killpix, req_fmt16} <= m;
    req_ch_off <= off;
    req_exec_mask <= ex;
    req_base_reg <= bs;
    {req_alpha, req_blue, req_green, req_red} <= {ch[3], ch[2], ch[1], ch[0]};
    {req_alive_mask, req_border_mask, req_null_mask} <= {al, bo, nu};
    do @(posedge pclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    need = m[0] ? m[3] : (m[1] | m[2]);
    fw = (!m[0] && m[1]) ? {16'hFFFF, 8'hFF, al} : {8'hFF, bo, 8'hFF, nu};
    tot = 4 - $countones(off) + int'(need);
    n = 0;
    for (int c = 0; c < 5; c++) begin
      if ((c < 4 && off[c[1:0]]) || (c == 4 && !need)) continue;
      b.rg = bs + 8'(n);
      b.flag = (c == 4);
      b.last = (n == tot - 1);
      b.hw_en = (c == 4) ? 16'h0003 : 16'h0000;
      b.data = (c == 4) ? {224'h0, fw} : (m[0] ? 256'h0 : ch[c[1:0]]);
      for (int i = 0; i < 8; i++)
        if (c < 4 && m[0]) begin
          b.data[16*i+:16] = ch[c[1:0]][32*i+:16];
          b.hw_en[i] = ex[i];
        end else if (c < 4) b.hw_en[2*i+:2] = {2{ex[i]}};
      q.push_back(b);
      n++;
    end
    exp_beats += tot;
  endtask

  always @(posedge pclk) begin
    if (presetn === 1'b1 && wb_valid === 1'b1 && wb_ready === 1'b1) begin
      if (q.size() == 0) begin
        miscompares++;
        $display("[FAIL] %0t beat with nothing expected", $time);
      end else begin
        e = q.pop_front();
        `CHK(wb_reg, e.rg, "register number")
        `CHK(wb_hw_en, e.hw_en, "lane enables")
        `CHK(wb_is_flag, e.flag, "flag beat")
        `CHK(wb_last, e.last, "last beat")
        if (e.flag)
          `CHK(wb_data, e.data, "flag word")
        else `CHK(wb_data, e.data, "channel data")
      end
    end
  end

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // a hang is cut well past the longest expected run
  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    conclude();
  end

  initial begin
    {presetn, psel, penable, pwrite, req_valid} = 5'h00;
    {paddr, pwdata, pace} = 46'h0;
    {req_fmt16, req_killpix, req_null_en, req_fault_en} = 4'h0;
    {req_ch_off, req_exec_mask, req_base_reg} = 20'h0;
    {req_red, req_green, req_blue, req_alpha} = 1024'h0;
    {req_alive_mask, req_border_mask, req_null_mask} = 24'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, swp_pkg::ADDR_CTRL, 32'h0);
    `CHK(rd, swp_pkg::CTRL_RST, "control reset value")
    apb(1'b0, swp_pkg::ADDR_REPLY_CNT, 32'h0);
    `CHK(rd, 32'h0, "reply count reset value")
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    `CHK(err, 1'b1, "unmapped access error")
    apb(1'b1, swp_pkg::ADDR_CTRL, 32'h0);
    @(posedge pclk);
    `CHK(req_ready, 1'b0, "disabled packer refuses")
    apb(1'b1, swp_pkg::ADDR_CTRL, swp_pkg::CTRL_RST);
    for (int i = 0; i < 96; i++) begin
      pace <= 2'(rnd());
      send_req({2'(rnd()), i[5:4]}, i[3:0]);
    end
    for (int k = 0; k < 5000 && q.size() > 0; k++) @(posedge pclk);
    // let the thread's beat count settle after the last handshake
    @(posedge pclk);
    `CHK(q.size(), 0, "replies outstanding")
    `CHK(beats, 16'(exp_beats), "beats taken by thread")
    apb(1'b0, swp_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[swp_pkg::STAT_BUSY_BIT], 1'b0, "idle after replies")
    conclude();
  end
endmodule // test_swp_packer
